// [rtl/tsc_pkg.sv]
// Package for the timer status and control stage.
// Notes on behaviour
// - Counter passing modulo sets wrap flag bit 7.
// - Flag clears by read-while-set then write zero.
// - Writing one to the flag changes nothing.
// - Wrap between read and write voids clear.
// - Enable bit 6 drives request while flag set.
// - Bit 5 selects up or up-down counting.
// - Bits 4-3 pick none, system, fixed, external.
// - Prescale field divides by two to value.
// - New prescale acts on the next cycle.
// - Counter and modulo compare are 16 bits.
// - Control write restarts both coherency buffers.
package tsc_pkg;
  localparam logic [3:0]  TSC_OFS_CTRL     = 4'h0;
  localparam logic [3:0]  TSC_OFS_COUNT    = 4'h4;
  localparam logic [3:0]  TSC_OFS_MODULO   = 4'h8;
  localparam logic [3:0]  TSC_OFS_HOLD     = 4'hC;
  localparam int          TSC_BIT_FLAG     = 7;
  localparam int          TSC_BIT_IRQ_EN   = 6;
  localparam int          TSC_BIT_CPWM     = 5;
  localparam int          TSC_BIT_CLK_HI   = 4;
  localparam int          TSC_BIT_CLK_LO   = 3;
  localparam int          TSC_BIT_PS_HI    = 2;
  localparam logic [7:0]  TSC_CTRL_RESET   = 8'h00;
  localparam logic [15:0] TSC_COUNT_RESET  = 16'h0000;
  localparam logic [15:0] TSC_MODULO_RESET = 16'h0000;
  localparam logic [15:0] TSC_COUNT_MAX    = 16'hFFFF;
  localparam logic [1:0]  TSC_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  TSC_RESP_SLVERR  = 2'h2;
  localparam logic [1:0]  TSC_CLK_NONE     = 2'h0;
  localparam logic [1:0]  TSC_CLK_SYSTEM   = 2'h1;
  localparam logic [1:0]  TSC_CLK_FIXED    = 2'h2;
  localparam logic [1:0]  TSC_CLK_EXTERNAL = 2'h3;

  typedef struct packed {
    logic       wrap_flag;
    logic       irq_en;
    logic       cpwm;
    logic [1:0] clk_sel;
    logic [2:0] ps;
  } tsc_ctrl_s;
endpackage

// [rtl/tsc_prescaler.sv]
// Clock source selection and binary prescaler.
`timescale 1ns/1ps
module tsc_prescaler (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] clk_sel,
  input  wire logic [2:0] ps,
  input  wire logic       fixed_clk_pin,
  input  wire logic       ext_clk_pin,
  output logic            tick
);
  import tsc_pkg::*;

  logic [2:0] fix_sync_r;
  logic [2:0] ext_sync_r;
  logic [6:0] div_r;
  logic [6:0] mask;
  logic       src_tick;

  // Two flops, then an edge stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fix_sync_r <= 3'h0;
      ext_sync_r <= 3'h0;
    end else begin
      fix_sync_r <= {fix_sync_r[1:0], fixed_clk_pin};
      ext_sync_r <= {ext_sync_r[1:0], ext_clk_pin};
    end
  end

  always_comb begin
    unique case (clk_sel)
      TSC_CLK_NONE:     src_tick = 1'b0;
      TSC_CLK_SYSTEM:   src_tick = 1'b1;
      TSC_CLK_FIXED:    src_tick = fix_sync_r[1] & ~fix_sync_r[2];
      TSC_CLK_EXTERNAL: src_tick = ext_sync_r[1] & ~ext_sync_r[2];
    endcase
  end

  // Mask of ps low ones, decoded as one shifted by ps minus one
  assign mask = 7'(({7'h00, 1'b1} << ps) - 8'h01);
  assign tick = src_tick & ((div_r & mask) == mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 7'h00;
    end else if (src_tick) begin
      div_r <= div_r + 7'h01;
    end
  end
endmodule

// [rtl/tsc_top.sv]
// Timer status and control stage with counter and AXI4-Lite slave.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module tsc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        fixed_clk_pin,
  input  wire logic        ext_clk_pin,
  output logic             wrap_irq,
  output logic             wrap_pulse,
  output logic             count_down,
  output logic             prescaled_tick,
  output logic [15:0]      count_value
);
  import tsc_pkg::*;

  tsc_ctrl_s   ctrl_r;
  logic [15:0] count_r;
  logic [15:0] modulo_r;
  logic [15:0] mod_buf_r;
  logic [1:0]  mod_loaded_r;
  logic [15:0] hold_r;
  logic        hold_valid_r;
  logic        down_r;
  logic        arm_r;
  logic        wrap_pulse_r;
  logic [3:0]  aw_addr_r;
  logic        aw_held_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        w_held_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        tick;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_mod;
  logic        rd_ctrl;
  logic        rd_count;
  logic        wrap_evt;
  logic        flag_clear;
  logic [15:0] top;
  logic [1:0]  mod_next;

  function automatic logic is_mapped(input logic [3:0] a);
    return a == TSC_OFS_CTRL || a == TSC_OFS_COUNT ||
           a == TSC_OFS_MODULO || a == TSC_OFS_HOLD;
  endfunction

  tsc_prescaler u_presc (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .clk_sel       (ctrl_r.clk_sel),
    .ps            (ctrl_r.ps),
    .fixed_clk_pin (fixed_clk_pin),
    .ext_clk_pin   (ext_clk_pin),
    .tick          (tick)
  );

  // Bus handshakes
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  assign wr_fire  = aw_held_r && w_held_r && !bvalid_r;
  assign rd_fire  = s_axi_arvalid && !rvalid_r;
  assign wr_ctrl  = wr_fire && aw_addr_r == TSC_OFS_CTRL && w_strb_r[0];
  assign wr_count = wr_fire && aw_addr_r == TSC_OFS_COUNT &&
                    (|w_strb_r[1:0]);
  assign wr_mod   = wr_fire && aw_addr_r == TSC_OFS_MODULO &&
                    (|w_strb_r[1:0]);
  assign rd_ctrl  = rd_fire && s_axi_araddr == TSC_OFS_CTRL;
  assign rd_count = rd_fire && s_axi_araddr == TSC_OFS_COUNT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
    end else if (s_axi_awvalid && !aw_held_r) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= {s_axi_awaddr[3:2], 2'h0};
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && !w_held_r) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= TSC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= is_mapped(aw_addr_r) ? TSC_RESP_OKAY : TSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= TSC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r  <= is_mapped({s_axi_araddr[3:2], 2'h0}) ?
                  TSC_RESP_OKAY : TSC_RESP_SLVERR;
      unique case ({s_axi_araddr[3:2], 2'h0})
        TSC_OFS_CTRL:   rdata_r <= {24'h000000, ctrl_r};
        TSC_OFS_COUNT:  rdata_r <= {16'h0000, count_r};
        TSC_OFS_MODULO: rdata_r <= {16'h0000, modulo_r};
        TSC_OFS_HOLD:   rdata_r <= {15'h0000, hold_valid_r, hold_r};
        default:        rdata_r <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Counter and wrap detection
  assign top = (modulo_r == TSC_MODULO_RESET) ? TSC_COUNT_MAX : modulo_r;
  assign wrap_evt = tick && !down_r && count_r >= top;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= TSC_COUNT_RESET;
      down_r  <= 1'b0;
    end else if (wr_count) begin
      count_r <= TSC_COUNT_RESET;
      down_r  <= 1'b0;
    end else if (!ctrl_r.cpwm) begin
      down_r <= 1'b0;
      if (tick) begin
        count_r <= wrap_evt ? TSC_COUNT_RESET : count_r + 16'h0001;
      end
    end else if (tick) begin
      if (wrap_evt) begin
        down_r  <= 1'b1;
        count_r <= count_r - 16'h0001;
      end else if (down_r && count_r == TSC_COUNT_RESET) begin
        down_r  <= 1'b0;
        count_r <= count_r + 16'h0001;
      end else if (down_r) begin
        count_r <= count_r - 16'h0001;
      end else begin
        count_r <= count_r + 16'h0001;
      end
    end
  end

  // Clear only when armed, writing zero, and no wrap since the read
  assign flag_clear = wr_ctrl && arm_r && !w_data_r[TSC_BIT_FLAG];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_r <= 1'b0;
    end else if (wrap_evt || wr_ctrl) begin
      arm_r <= 1'b0;
    end else if (rd_ctrl && ctrl_r.wrap_flag) begin
      arm_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= TSC_CTRL_RESET;
    end else begin
      if (wrap_evt) begin
        ctrl_r.wrap_flag <= 1'b1;
      end else if (flag_clear) begin
        ctrl_r.wrap_flag <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_r.irq_en  <= w_data_r[TSC_BIT_IRQ_EN];
        ctrl_r.cpwm    <= w_data_r[TSC_BIT_CPWM];
        ctrl_r.clk_sel <= w_data_r[TSC_BIT_CLK_HI:TSC_BIT_CLK_LO];
        ctrl_r.ps      <= w_data_r[TSC_BIT_PS_HI:0];
      end
    end
  end

  // Modulo write buffer, updated once both bytes are in
  assign mod_next = mod_loaded_r | w_strb_r[1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modulo_r     <= TSC_MODULO_RESET;
      mod_buf_r    <= TSC_MODULO_RESET;
      mod_loaded_r <= 2'h0;
    end else if (wr_ctrl) begin
      mod_loaded_r <= 2'h0;
    end else if (wr_mod) begin
      if (w_strb_r[0]) mod_buf_r[7:0] <= w_data_r[7:0];
      if (w_strb_r[1]) mod_buf_r[15:8] <= w_data_r[15:8];
      if (mod_next == 2'h3) begin
        modulo_r[7:0]  <= w_strb_r[0] ? w_data_r[7:0] : mod_buf_r[7:0];
        modulo_r[15:8] <= w_strb_r[1] ? w_data_r[15:8] : mod_buf_r[15:8];
        mod_loaded_r   <= 2'h0;
      end else begin
        mod_loaded_r <= mod_next;
      end
    end
  end

  // Counter read coherency buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_r       <= TSC_COUNT_RESET;
      hold_valid_r <= 1'b0;
    end else if (wr_ctrl || wr_count) begin
      hold_valid_r <= 1'b0;
    end else if (rd_count) begin
      hold_r       <= count_r;
      hold_valid_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_pulse_r <= 1'b0;
    end else begin
      wrap_pulse_r <= wrap_evt;
    end
  end

  assign wrap_irq       = ctrl_r.wrap_flag & ctrl_r.irq_en;
  assign wrap_pulse     = wrap_pulse_r;
  assign count_down     = down_r;
  assign prescaled_tick = tick;
  assign count_value    = count_r;
endmodule

// [sim/tsc_monitor.sv]
// Port checks for the timer status and control stage.
`timescale 1ns/1ps
module tsc_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        wrap_irq,
  input wire logic        prescaled_tick,
  input wire logic        count_down,
  input wire logic [15:0] count_value
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic idle;
  // No register write lands in a cycle with an address or data slot free
  assign idle = s_axi_awready || s_axi_wready || s_axi_bvalid;
  chk_count_no_tick: assert property (!prescaled_tick && idle |=>
    $stable(count_value)) else $error("count moved without tick");
  chk_count_up_step: assert property (prescaled_tick && idle &&
    !count_down |=> count_down || count_value == 16'h0 ||
    count_value == $past(count_value) + 16'h1)
    else $error("bad up step");
  chk_count_dn_step: assert property (prescaled_tick && idle &&
    count_down |=> !count_down ||
    count_value == $past(count_value) - 16'h1)
    else $error("bad down step");
  chk_irq_fall_write: assert property ($fell(wrap_irq) |->
    $rose(s_axi_bvalid)) else $error("irq dropped without write");
  chk_write_resp: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no write response");
  chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no read response");
  chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  chk_rvalid_cause: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
endmodule

// [sim/timer_status_control_bench.sv]
// Self-checking bench for the timer status and control stage.
`timescale 1ns/1ps
module timer_status_control_bench;
  import tsc_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  logic        s_axi_bready, s_axi_rready, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        fixed_clk_pin, ext_clk_pin, wrap_irq, wrap_pulse;
  logic        count_down, prescaled_tick;
  logic [15:0] count_value;
  int          n_errors, cmp_count, n, k, ph;
  tsc_top u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fixed_clk_pin, .ext_clk_pin, .wrap_irq, .wrap_pulse, .count_down,
    .prescaled_tick, .count_value
  );
  always #50 aclk = ~aclk;
  // Fixed clock period 8 cycles, external clock period 12 cycles
  always @(posedge aclk) begin
    ph <= ph + 1;
    fixed_clk_pin <= (ph % 8) < 4;
    ext_clk_pin <= (ph % 12) < 6;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Each channel is released at the edge that takes it
    do begin
      @(posedge aclk);
      aw_ok = aw_ok || s_axi_awready;
      w_ok = w_ok || s_axi_wready;
      if (aw_ok)
        s_axi_awvalid <= 1'b0;
      if (w_ok)
        s_axi_wvalid <= 1'b0;
    end while (!(aw_ok && w_ok));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    chk({30'h0, s_axi_bresp}, {30'h0, TSC_RESP_OKAY});
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, TSC_RESP_OKAY});
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    rd(a, rv);
    chk(rv, e);
  endtask
  task automatic meas(output int c);
    c = 0;
    do @(negedge aclk); while (!prescaled_tick);
    do begin
      @(negedge aclk);
      c++;
    end while (!prescaled_tick);
  endtask
  task automatic results;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    results();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_bready, s_axi_rready} = '0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc(TSC_OFS_CTRL, {24'h0, TSC_CTRL_RESET});
    for (int p = 0; p < 8; p++) begin
      wr(TSC_OFS_CTRL, 32'h08 | p);
      meas(n);
      chk(n, 1 << p);
    end
    wr(TSC_OFS_CTRL, 32'h10);
    meas(n);
    chk(n, 8);
    wr(TSC_OFS_CTRL, 32'h18);
    meas(n);
    chk(n, 12);
    wr(TSC_OFS_CTRL, 32'h00);
    n = 0;
    repeat (60) @(negedge aclk) n += prescaled_tick;
    chk(n, 0);
    wr(TSC_OFS_MODULO, 32'h3);
    wr(TSC_OFS_COUNT, 32'h0);
    wr(TSC_OFS_CTRL, 32'h48);
    do @(negedge aclk); while (!wrap_irq);
    wr(TSC_OFS_CTRL, 32'h40);
    rc(TSC_OFS_CTRL, 32'hC0);
    wr(TSC_OFS_CTRL, 32'h80);
    @(negedge aclk);
    chk(wrap_irq, 1'b0);
    rc(TSC_OFS_CTRL, 32'h80);
    wr(TSC_OFS_CTRL, 32'h40);
    rc(TSC_OFS_CTRL, 32'h40);
    wr(TSC_OFS_CTRL, 32'h08);
    do @(negedge aclk); while (!wrap_pulse);
    rd(TSC_OFS_CTRL, rv);
    do @(negedge aclk); while (!wrap_pulse);
    wr(TSC_OFS_CTRL, 32'h00);
    rc(TSC_OFS_CTRL, 32'h80);
    for (int m = 0; m < 2; m++) begin
      wr(TSC_OFS_CTRL, m ? 32'h28 : 32'h08);
      n = 0;
      repeat (16) begin
        k = count_value;
        @(negedge aclk);
        if (count_value == k - 1) n = 1;
      end
      chk(n, m);
    end
    rd(TSC_OFS_COUNT, rv);
    rd(TSC_OFS_HOLD, rv);
    chk(rv[16], 1'b1);
    wr(TSC_OFS_CTRL, 32'h00);
    rd(TSC_OFS_HOLD, rv);
    chk(rv[16], 1'b0);
    results();
  end
endmodule
bind tsc_top tsc_monitor u_mon (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .wrap_irq, .prescaled_tick, .count_down, .count_value
);
